// >>> hw/rtcs_regs.svh
// Register map, field positions, reset values and timing counts of the clock block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH
`define RTCS_A_CTRL 4'h0
`define RTCS_A_DSTMODE 4'h1
`define RTCS_A_TZ 4'h2
`define RTCS_A_DAYS 4'h3
`define RTCS_A_START 4'h4
`define RTCS_A_DUR 4'h5
`define RTCS_A_DATE 4'h6
`define RTCS_A_TIME 4'h7
`define RTCS_A_STS 4'h8
`define RTCS_A_MASK 4'h9
`define RTCS_A_STATE 4'hA
`define RTCS_F_WDAY 24
`define RTCS_F_YEAR 16
`define RTCS_F_MON 8
`define RTCS_F_HOUR 16
`define RTCS_F_MIN 8
`define RTCS_F_SHOUR 8
`define RTCS_S_CHG 0
`define RTCS_S_TBEG 1
`define RTCS_S_TEND 2
`define RTCS_RST_DAY 5'h01
`define RTCS_RST_MON 4'h1
`define RTCS_CLK_PERIOD_NS 20
`define RTCS_SEC_NS 1000000000
`define RTCS_TICK_CYCLES (`RTCS_SEC_NS / `RTCS_CLK_PERIOD_NS)
`define RTCS_NTP_PERIOD_MIN 5
`define RTCS_MIN_S 60
`define RTCS_HOUR_S 3600
`define RTCS_HOUR_MIN 60
`define RTCS_NTP_PERIOD_S (`RTCS_NTP_PERIOD_MIN * `RTCS_MIN_S)
`define RTCS_CHANGE_LIMIT_S 60
`define RTCS_DAY_S 86400
`define RTCS_DAY_MIN 1440
`define RTCS_TZ_MIN (-47)
`define RTCS_TZ_MAX 48
`define RTCS_TZ_STEP_MIN 15
`define RTCS_EURO_HOUR 1
`endif

// >>> hw/rtcs_pkg.sv
// Types and calendar arithmetic shared by the clock block.
// Assumes years counted from a leap year, so every fourth year is a leap year.
`default_nettype none
package rtcs_pkg;
  typedef enum logic [2:0] {RTCS_DST_NONE, RTCS_DST_ALWAYS, RTCS_DST_EURO, RTCS_DST_CAL, RTCS_DST_CLOUD}
    rtcs_dst_mode_t;
  typedef enum logic {RTCS_IDLE, RTCS_RUN} rtcs_test_st_t;
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] day;
    logic [2:0] wday;
  } rtcs_date_t;

  function automatic logic [4:0] rtcs_mdays(input logic [6:0] y, input logic [3:0] m);
    case (m)
      4'h2: return (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: return 5'h1E;
      default: return 5'h1F;
    endcase
  endfunction

  function automatic rtcs_date_t rtcs_next_day(input rtcs_date_t d);
    rtcs_date_t n;
    n = d;
    n.wday = (d.wday == 3'h6) ? 3'h0 : d.wday + 3'h1;
    if (d.day >= rtcs_mdays(d.year, d.mon)) begin
      n.day = 5'h01;
      n.mon = (d.mon == 4'hC) ? 4'h1 : d.mon + 4'h1;
      n.year = (d.mon == 4'hC) ? d.year + 7'h01 : d.year;
    end else begin
      n.day = d.day + 5'h01;
    end
    return n;
  endfunction

  function automatic rtcs_date_t rtcs_prev_day(input rtcs_date_t d);
    rtcs_date_t n;
    n = d;
    n.wday = (d.wday == 3'h0) ? 3'h6 : d.wday - 3'h1;
    if (d.day == 5'h01) begin
      n.mon = (d.mon == 4'h1) ? 4'hC : d.mon - 4'h1;
      n.year = (d.mon == 4'h1) ? d.year - 7'h01 : d.year;
      n.day = rtcs_mdays(n.year, n.mon);
    end else begin
      n.day = d.day - 5'h01;
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// >>> hw/rtcs_euro_dst.sv
// European summer-time decision from a universal date and hour.
// Assumes weekday 0 is Sunday and a valid calendar date at its inputs.
`include "rtcs_regs.svh"
`default_nettype none
module rtcs_euro_dst (
  input wire logic [3:0] mon,
  input wire logic [4:0] day,
  input wire logic [2:0] wday,
  input wire logic [4:0] hour,
  output logic active
);
  logic [5:0] w31;
  logic [4:0] last_sun;
  always_comb begin
    // Weekday of the 31st, then the last Sunday of a 31-day month
    w31 = 6'((6'(wday) + 6'h1F - 6'(day)) % 6'h07);
    last_sun = 5'h1F - 5'(w31);
    case (mon)
      4'h3: active = (day > last_sun) || (day == last_sun && hour >= 5'(`RTCS_EURO_HOUR));
      4'hA: active = (day < last_sun) || (day == last_sun && hour < 5'(`RTCS_EURO_HOUR));
      default: active = (mon > 4'h3) && (mon < 4'hA);
    endcase
  end
endmodule
`default_nettype wire

// >>> hw/rtcs_sched.sv
// Weekly engine-test request with a minute counter for the run length.
// Assumes min_tick pulses in the first cycle in which the clock shows a new minute.
`include "rtcs_regs.svh"
`default_nettype none
module rtcs_sched import rtcs_pkg::*; #(
  parameter int DUR_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic min_tick,
  input wire logic [2:0] wday,
  input wire logic [4:0] hour,
  input wire logic [5:0] minute,
  input wire logic [6:0] days,
  input wire logic [4:0] st_hour,
  input wire logic [5:0] st_min,
  input wire logic [DUR_W-1:0] dur,
  input wire logic remote_start,
  output logic test_req,
  output logic test_begin,
  output logic test_end
);
  rtcs_test_st_t st_q;
  logic [DUR_W-1:0] cnt_q;
  logic due;

  // No engine-run history enters here: a due test starts whenever no test is running
  assign due = min_tick && days[wday] && hour == st_hour && minute == st_min && dur != '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= RTCS_IDLE;
      cnt_q <= '0;
      test_req <= 1'b0;
      test_begin <= 1'b0;
      test_end <= 1'b0;
    end else begin
      test_begin <= 1'b0;
      test_end <= 1'b0;
      if (remote_start && dur != '0) begin
        st_q <= RTCS_RUN;
        cnt_q <= '0;
        test_req <= 1'b1;
        test_begin <= (st_q == RTCS_IDLE);
      end else begin
        case (st_q)
          RTCS_IDLE: if (due) begin
            st_q <= RTCS_RUN;
            cnt_q <= '0;
            test_req <= 1'b1;
            test_begin <= 1'b1;
          end
          RTCS_RUN: if (min_tick) begin
            // Counts minutes, not clock readings, so a run across midnight ends correctly
            if (cnt_q + DUR_W'(1) >= dur) begin
              st_q <= RTCS_IDLE;
              test_req <= 1'b0;
              test_end <= 1'b1;
            end else begin
              cnt_q <= cnt_q + DUR_W'(1);
            end
          end
          default: begin
            st_q <= RTCS_IDLE;
            test_req <= 1'b0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TEST_DUE: assert property (due && st_q == RTCS_IDLE |=> test_req && test_begin)
    else $error("due test not started");
  AST_TEST_DAYOFF: assert property (min_tick && !days[wday] && st_q == RTCS_IDLE && !remote_start |=> !test_req)
    else $error("test started on unselected day");
  AST_TEST_END: assert property (st_q == RTCS_RUN && min_tick && !remote_start && cnt_q == dur - DUR_W'(1)
    |=> !test_req && test_end)
    else $error("test did not end at duration");
  AST_TEST_HOLD: assert property (test_req && !min_tick |=> test_req)
    else $error("test ended between minutes");
  AST_REMOTE: assert property (remote_start && dur != '0 |=> test_req && cnt_q == '0)
    else $error("remote test not started");
  COV_TEST_BEGIN: cover property (test_begin);
  COV_TEST_END: cover property (test_end);
endmodule
`default_nettype wire

// >>> hw/rtcs_top.sv
// Real-time clock with time-server update, zone and summer-time handling, and weekly test request.
// Assumes all inputs synchronous to clk and a plain register port with read data one cycle later.
//
// Behaviour
// - With network sync enabled, request a server query once every five minutes.
// - Local time from server is universal time plus zone offset plus summer hour.
// - Cloud reply time is loaded as received; zone and summer settings ignored.
// - Log a time-changed event only when new time differs by over one minute.
// - Summer mode: 0 none, 1 always, 2 European, 3 calendars, 4 cloud.
// - European mode: on 01:00 last Sunday of March, off last Sunday October.
// - Calendar mode: calendar 15 switches summer time on, calendar 16 off.
// - Zone offset counts quarter hours; four equals one hour.
// - Accept zone offset writes only between -47 and +48.
// - Test-day mask has one bit per weekday, bit 0 Sunday to bit 6 Saturday.
// - One start time in hours and minutes serves every selected day.
// - Test duration is held in minutes.
// - Remote text-message test uses the same duration as scheduled tests.
// - Scheduled test starts regardless of recent engine runs.
//
// Chosen here: the register offsets and strobed register access.
`include "rtcs_regs.svh"
`default_nettype none
module rtcs_top import rtcs_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `RTCS_TICK_CYCLES,
  parameter int unsigned NTP_PERIOD_S = `RTCS_NTP_PERIOD_S,
  parameter int DUR_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic ntp_valid,
  input wire logic [6:0] ntp_year,
  input wire logic [3:0] ntp_mon,
  input wire logic [4:0] ntp_day,
  input wire logic [2:0] ntp_wday,
  input wire logic [4:0] ntp_hour,
  input wire logic [5:0] ntp_min,
  input wire logic [5:0] ntp_sec,
  input wire logic cloud_valid,
  input wire logic [6:0] cloud_year,
  input wire logic [3:0] cloud_mon,
  input wire logic [4:0] cloud_day,
  input wire logic [2:0] cloud_wday,
  input wire logic [4:0] cloud_hour,
  input wire logic [5:0] cloud_min,
  input wire logic [5:0] cloud_sec,
  input wire logic cloud_dst,
  input wire logic cal15_out,
  input wire logic cal16_out,
  input wire logic remote_test_start,
  output logic ntp_req,
  output logic time_changed_event,
  output logic test_req,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int NW = $clog2(NTP_PERIOD_S + 1);

  logic [6:0] year_q;
  logic [3:0] mon_q;
  logic [4:0] day_q;
  logic [2:0] wday_q;
  logic [4:0] hour_q;
  logic [5:0] min_q, sec_q;
  logic ntp_en_q, dst_q, cal15_q, cal16_q;
  rtcs_dst_mode_t dst_mode_q;
  logic signed [6:0] tz_q;
  logic [6:0] days_q;
  logic [4:0] st_hour_q;
  logic [5:0] st_min_q;
  logic [DUR_W-1:0] dur_q;
  logic [2:0] sts_q, sts_d, mask_q;
  logic [TW-1:0] tick_cnt_q;
  logic [NW-1:0] ntp_cnt_q;
  logic ntp_req_q, min_tick_q, chg_q, irq_q;
  logic [31:0] rdata_q;
  logic sec_tick, wr_time, wr_date, wr_tz_ok;
  logic euro_on, dst_eff, ld_valid, chg, test_begin, test_end;
  rtcs_date_t cur_d, udate, cdate, ld_date;
  logic [4:0] conv_hour, ld_hour;
  logic [5:0] conv_min, ld_min, ld_sec;
  int lm, cs, ns;

  function automatic int rtcs_sod(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
    return int'(h) * `RTCS_HOUR_S + int'(m) * `RTCS_MIN_S + int'(s);
  endfunction

  function automatic logic rtcs_same(input rtcs_date_t a, input rtcs_date_t b);
    return a.year == b.year && a.mon == b.mon && a.day == b.day;
  endfunction

  assign sec_tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
  assign wr_time = wr_en && addr == `RTCS_A_TIME;
  assign wr_date = wr_en && addr == `RTCS_A_DATE;
  assign wr_tz_ok = $signed(wdata[6:0]) >= 7'sh51 && $signed(wdata[6:0]) <= 7'sh30;
  assign cur_d = {year_q, mon_q, day_q, wday_q};
  assign udate = {ntp_year, ntp_mon, ntp_day, ntp_wday};

  rtcs_euro_dst u_euro (
    .mon(ntp_mon),
    .day(ntp_day),
    .wday(ntp_wday),
    .hour(ntp_hour),
    .active(euro_on)
  );

  always_comb begin
    case (dst_mode_q)
      RTCS_DST_NONE: dst_eff = 1'b0;
      RTCS_DST_ALWAYS: dst_eff = 1'b1;
      RTCS_DST_EURO: dst_eff = euro_on;
      RTCS_DST_CAL, RTCS_DST_CLOUD: dst_eff = dst_q;
      default: dst_eff = 1'b0;
    endcase
  end

  // Offset is at most twelve hours, so one day step either way is enough
  always_comb begin
    lm = int'(ntp_hour) * `RTCS_HOUR_MIN + int'(ntp_min) + int'(tz_q) * `RTCS_TZ_STEP_MIN
      + (dst_eff ? `RTCS_HOUR_MIN : 0);
    cdate = udate;
    if (lm < 0) begin
      lm = lm + `RTCS_DAY_MIN;
      cdate = rtcs_prev_day(udate);
    end else if (lm >= `RTCS_DAY_MIN) begin
      lm = lm - `RTCS_DAY_MIN;
      cdate = rtcs_next_day(udate);
    end
    conv_hour = 5'(lm / `RTCS_HOUR_MIN);
    conv_min = 6'(lm % `RTCS_HOUR_MIN);
  end

  // Cloud reply wins when both sources answer in the same cycle
  always_comb begin
    ld_valid = cloud_valid || ntp_valid;
    if (cloud_valid) begin
      ld_date = {cloud_year, cloud_mon, cloud_day, cloud_wday};
      ld_hour = cloud_hour;
      ld_min = cloud_min;
      ld_sec = cloud_sec;
    end else begin
      ld_date = cdate;
      ld_hour = conv_hour;
      ld_min = conv_min;
      ld_sec = ntp_sec;
    end
  end

  always_comb begin
    cs = rtcs_sod(hour_q, min_q, sec_q);
    ns = rtcs_sod(ld_hour, ld_min, ld_sec);
    if (rtcs_same(ld_date, cur_d)) begin
      chg = (ns - cs > `RTCS_CHANGE_LIMIT_S) || (cs - ns > `RTCS_CHANGE_LIMIT_S);
    end else if (rtcs_same(ld_date, rtcs_next_day(cur_d))) begin
      chg = (`RTCS_DAY_S - cs + ns > `RTCS_CHANGE_LIMIT_S);
    end else if (rtcs_same(ld_date, rtcs_prev_day(cur_d))) begin
      chg = (`RTCS_DAY_S - ns + cs > `RTCS_CHANGE_LIMIT_S);
    end else begin
      chg = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || sec_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // Software setting beats a server load, which beats the running second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {year_q, mon_q, day_q, wday_q} <= {7'h00, `RTCS_RST_MON, `RTCS_RST_DAY, 3'h0};
      {hour_q, min_q, sec_q} <= 17'h00000;
    end else if (wr_time || wr_date) begin
      if (wr_date) begin
        year_q <= wdata[`RTCS_F_YEAR +: 7];
        mon_q <= wdata[`RTCS_F_MON +: 4];
        day_q <= wdata[4:0];
        wday_q <= wdata[`RTCS_F_WDAY +: 3];
      end
      if (wr_time) begin
        hour_q <= wdata[`RTCS_F_HOUR +: 5];
        min_q <= wdata[`RTCS_F_MIN +: 6];
        sec_q <= wdata[5:0];
      end
    end else if (ld_valid) begin
      {year_q, mon_q, day_q, wday_q} <= ld_date;
      {hour_q, min_q, sec_q} <= {ld_hour, ld_min, ld_sec};
    end else if (sec_tick) begin
      if (sec_q == 6'h3B) begin
        sec_q <= 6'h00;
        if (min_q == 6'h3B) begin
          min_q <= 6'h00;
          if (hour_q == 5'h17) begin
            hour_q <= 5'h00;
            {year_q, mon_q, day_q, wday_q} <= rtcs_next_day(cur_d);
          end else begin
            hour_q <= hour_q + 5'h01;
          end
        end else begin
          min_q <= min_q + 6'h01;
        end
      end else begin
        sec_q <= sec_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      min_tick_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      min_tick_q <= sec_tick && sec_q == 6'h3B && !wr_time && !wr_date && !ld_valid;
      chg_q <= ld_valid && !wr_time && !wr_date && chg;
    end
  end

  // Counts seconds, so the five-minute period costs only a small counter
  always_ff @(posedge clk) begin
    if (!rst_n || !ntp_en_q) begin
      ntp_cnt_q <= '0;
      ntp_req_q <= 1'b0;
    end else begin
      ntp_req_q <= 1'b0;
      if (sec_tick) begin
        if (ntp_cnt_q == NW'(NTP_PERIOD_S - 1)) begin
          ntp_cnt_q <= '0;
          ntp_req_q <= 1'b1;
        end else begin
          ntp_cnt_q <= ntp_cnt_q + NW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dst_q <= 1'b0;
      cal15_q <= 1'b0;
      cal16_q <= 1'b0;
    end else begin
      cal15_q <= cal15_out;
      cal16_q <= cal16_out;
      if (cloud_valid && dst_mode_q == RTCS_DST_CLOUD) begin
        dst_q <= cloud_dst;
      end else if (dst_mode_q == RTCS_DST_CAL) begin
        if (cal15_out && !cal15_q) begin
          dst_q <= 1'b1;
        end else if (cal16_out && !cal16_q) begin
          dst_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ntp_en_q <= 1'b0;
      dst_mode_q <= RTCS_DST_NONE;
      tz_q <= 7'sh00;
      days_q <= 7'h00;
      st_hour_q <= 5'h00;
      st_min_q <= 6'h00;
      dur_q <= '0;
      mask_q <= 3'h0;
    end else if (wr_en) begin
      case (addr)
        `RTCS_A_CTRL: ntp_en_q <= wdata[0];
        `RTCS_A_DSTMODE: if (wdata[2:0] <= 3'h4) dst_mode_q <= rtcs_dst_mode_t'(wdata[2:0]);
        `RTCS_A_TZ: if (wr_tz_ok) tz_q <= $signed(wdata[6:0]);
        `RTCS_A_DAYS: days_q <= wdata[6:0];
        `RTCS_A_START: begin
          st_hour_q <= wdata[`RTCS_F_SHOUR +: 5];
          st_min_q <= wdata[5:0];
        end
        `RTCS_A_DUR: dur_q <= wdata[DUR_W-1:0];
        `RTCS_A_MASK: mask_q <= wdata[2:0];
        default: ;
      endcase
    end
  end

  rtcs_sched #(.DUR_W(DUR_W)) u_sched (
    .clk(clk),
    .rst_n(rst_n),
    .min_tick(min_tick_q),
    .wday(wday_q),
    .hour(hour_q),
    .minute(min_q),
    .days(days_q),
    .st_hour(st_hour_q),
    .st_min(st_min_q),
    .dur(dur_q),
    .remote_start(remote_test_start),
    .test_req(test_req),
    .test_begin(test_begin),
    .test_end(test_end)
  );

  // A new event in the clearing cycle survives
  always_comb begin
    sts_d = sts_q & ~((wr_en && addr == `RTCS_A_STS) ? wdata[2:0] : 3'h0);
    sts_d[`RTCS_S_CHG] = sts_d[`RTCS_S_CHG] | chg_q;
    sts_d[`RTCS_S_TBEG] = sts_d[`RTCS_S_TBEG] | test_begin;
    sts_d[`RTCS_S_TEND] = sts_d[`RTCS_S_TEND] | test_end;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sts_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & mask_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !rd_en) begin
      rdata_q <= 32'h00000000;
    end else begin
      case (addr)
        `RTCS_A_CTRL: rdata_q <= {31'h00000000, ntp_en_q};
        `RTCS_A_DSTMODE: rdata_q <= {29'h00000000, dst_mode_q};
        `RTCS_A_TZ: rdata_q <= {{25{tz_q[6]}}, tz_q};
        `RTCS_A_DAYS: rdata_q <= {25'h0000000, days_q};
        `RTCS_A_START: rdata_q <= {19'h00000, st_hour_q, 2'h0, st_min_q};
        `RTCS_A_DUR: rdata_q <= 32'(dur_q);
        `RTCS_A_DATE: rdata_q <= {5'h00, wday_q, 1'b0, year_q, 4'h0, mon_q, 3'h0, day_q};
        `RTCS_A_TIME: rdata_q <= {11'h000, hour_q, 2'h0, min_q, 2'h0, sec_q};
        `RTCS_A_STS: rdata_q <= {29'h00000000, sts_q};
        `RTCS_A_MASK: rdata_q <= {29'h00000000, mask_q};
        `RTCS_A_STATE: rdata_q <= {30'h00000000, test_req, dst_eff};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign rdata = rdata_q;
  assign ntp_req = ntp_req_q;
  assign time_changed_event = chg_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_NTP_PERIOD: assert property (ntp_req_q |-> $past(ntp_en_q) && $past(sec_tick)
    && $past(ntp_cnt_q) == NW'(NTP_PERIOD_S - 1))
    else $error("server query outside its period");
  AST_LOCAL_UTC: assert property (ntp_valid && !cloud_valid && !wr_en && tz_q == 7'sh00 && !dst_eff
    |=> hour_q == $past(ntp_hour) && min_q == $past(ntp_min) && day_q == $past(ntp_day))
    else $error("universal time not loaded as local");
  AST_TZ_HOUR: assert property (ntp_valid && !cloud_valid && !wr_en && tz_q == 7'sh04 && !dst_eff
    && ntp_hour < 5'h17 |=> hour_q == $past(ntp_hour) + 5'h01 && min_q == $past(ntp_min))
    else $error("four quarter hours not one hour");
  AST_DST_ALWAYS: assert property (ntp_valid && !cloud_valid && !wr_en && tz_q == 7'sh00
    && dst_mode_q == RTCS_DST_ALWAYS && ntp_hour < 5'h17 |=> hour_q == $past(ntp_hour) + 5'h01)
    else $error("summer hour not added");
  AST_CLOUD_DIRECT: assert property (cloud_valid && !wr_en |=> hour_q == $past(cloud_hour)
    && min_q == $past(cloud_min) && sec_q == $past(cloud_sec) && day_q == $past(cloud_day))
    else $error("cloud time altered");
  AST_EVT_SMALL: assert property (ld_valid && !wr_en && rtcs_same(ld_date, cur_d)
    && ns - cs <= `RTCS_CHANGE_LIMIT_S && cs - ns <= `RTCS_CHANGE_LIMIT_S |=> !time_changed_event)
    else $error("event logged for small change");
  AST_EVT_BIG: assert property (ld_valid && !wr_en && rtcs_same(ld_date, cur_d) && ns - cs > 120
    |=> time_changed_event ##1 sts_q[`RTCS_S_CHG])
    else $error("large change not logged");
  AST_EURO: assert property (dst_mode_q == RTCS_DST_EURO && ntp_mon inside {4'h1, 4'h2, 4'hB, 4'hC}
    |-> !dst_eff)
    else $error("summer time in winter month");
  AST_EURO_SUMMER: assert property (dst_mode_q == RTCS_DST_EURO && ntp_mon inside {[4'h4:4'h9]} |-> dst_eff)
    else $error("no summer time in summer month");
  AST_CAL_ON: assert property (dst_mode_q == RTCS_DST_CAL && cal15_out && !cal15_q && !wr_en |=> dst_q)
    else $error("calendar 15 did not switch on");
  AST_TZ_RANGE: assert property (wr_en && addr == `RTCS_A_TZ && !wr_tz_ok |=> $stable(tz_q))
    else $error("out-of-range zone offset accepted");
  COV_NTP_CHG: cover property (ntp_valid && chg ##1 time_changed_event);
  COV_DAY_BACK: cover property (ntp_valid && lm != int'(ntp_hour) && rtcs_same(cdate, rtcs_prev_day(udate)));
  COV_CLOUD: cover property (cloud_valid && !chg);
endmodule
`default_nettype wire

// >>> tb/rtcs_tsrc.sv
// Time-server model: answers each time request with a fixed universal time of day.
// Assumes requests are one-cycle pulses synchronous to clk.
`default_nettype none
module rtcs_tsrc #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic ask,
  output logic valid,
  output logic [4:0] hour,
  output logic [5:0] min
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LAT-1:0] pipe_q = '0;
  // Latency is a parameter so a slow server can be modelled too
  always @(posedge clk) pipe_q <= {pipe_q[LAT-2:0], ask};
  assign valid = pipe_q[LAT-1];
  // Fields mean nothing without valid, so they show a wrong value then
  assign hour = valid ? 5'h0A : 5'h15;
  assign min = valid ? 6'h00 : 6'h3F;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the clock block with a time-server model.
// Assumes short second and query counts set through the top parameters.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rtcs_pkg::*;
  typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] r;} rtcs_row_t;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, c_v = 0, c_dst = 0, c15 = 0, c16 = 0, rts = 0, e;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata, d;
  rtcs_date_t c_date = '{7'h00, 4'h1, 5'h01, 3'h0};
  logic [4:0] c_hour = 5'h0D, n_hour;
  logic [5:0] c_min = 6'h1E, n_min;
  logic ntp_req, ntp_valid, evt, test_req, irq;
  int err_total = 0, checked = 0, k;
  rtcs_row_t rows[11] = '{'{4'h2, 32'h4, 32'h4}, '{4'h2, 32'h31, 32'h4}, '{4'h2, 32'h51, 32'hFFFFFFD1},
    '{4'h2, 32'h4, 32'h4}, '{4'h1, 32'h1, 32'h1}, '{4'h1, 32'h5, 32'h1}, '{4'h3, 32'h1, 32'h1},
    '{4'h4, 32'h900, 32'h900}, '{4'h5, 32'h1, 32'h1}, '{4'h9, 32'h3, 32'h3}, '{4'hF, 32'h1, 32'h0}};
  always #10 clk = ~clk;
  rtcs_tsrc u_src (.clk(clk), .ask(ntp_req), .valid(ntp_valid), .hour(n_hour), .min(n_min));
  rtcs_top #(.TICK_CYCLES(4), .NTP_PERIOD_S(3)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ntp_valid(ntp_valid),
    .ntp_year(c_date.year), .ntp_mon(c_date.mon), .ntp_day(c_date.day), .ntp_wday(c_date.wday),
    .ntp_hour(n_hour), .ntp_min(n_min), .ntp_sec(n_min), .cloud_valid(c_v), .cloud_year(c_date.year),
    .cloud_mon(c_date.mon), .cloud_day(c_date.day), .cloud_wday(c_date.wday), .cloud_hour(c_hour),
    .cloud_min(c_min), .cloud_sec(c_min), .cloud_dst(c_dst), .cal15_out(c15), .cal16_out(c16),
    .remote_test_start(rts), .ntp_req(ntp_req), .time_changed_event(evt), .test_req(test_req), .irq(irq));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk("reset outputs", 32'h0, {test_req, irq, ntp_req, evt});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("register", rows[i].r, d);
    end
    wr(4'h0, 32'h1);
    for (k = 0; k < 60 && ntp_req !== 1'b1; k++) tick();
    e = 0;
    for (k = 1; k < 40; k++) begin
      tick();
      e |= evt;
      if (ntp_req === 1'b1) break;
    end
    chk("event on big change", 1, e);
    chk("query period", 12, k);
    e = 0;
    repeat (6) begin
      tick();
      e |= evt;
    end
    chk("event on small change", 0, e);
    wr(4'h0, 32'h0);
    rd(4'h7);
    chk("local time", 13'h0C00, d[20:8]);
    chk("irq on change", 1, irq);
    wr(4'h8, 32'h7);
    tick();
    tick();
    chk("irq cleared", 0, irq);
    @(posedge clk);
    c_v <= 1'b1;
    @(posedge clk);
    c_v <= 1'b0;
    rd(4'h7);
    chk("cloud time", 13'h0D1E, d[20:8]);
    wr(4'h7, 32'h00083B3A);
    for (k = 0; k < 60 && test_req !== 1'b1; k++) tick();
    chk("scheduled start", 1, test_req);
    for (k = 1; k < 300; k++) begin
      tick();
      if (test_req !== 1'b1) break;
    end
    chk("test length", 240, k);
    wr(4'h8, 32'h7);
    @(posedge clk);
    rts <= 1'b1;
    @(posedge clk);
    rts <= 1'b0;
    #1 chk("remote start", 1, test_req);
    tick();
    tick();
    chk("irq on test", 1, irq);
    wr(4'h2, 32'h0);
    wr(4'h1, 32'h0);
    wr(4'h0, 32'h1);
    for (k = 0; k < 60 && ntp_req !== 1'b1; k++) tick();
    repeat (3) tick();
    wr(4'h0, 32'h0);
    rd(4'h7);
    chk("universal time", 13'h0A00, d[20:8]);
    wr(4'h1, 32'h3);
    c15 <= 1'b1;
    rd(4'hA);
    chk("calendar on", 1, d[0]);
    @(posedge clk);
    c16 <= 1'b1;
    rd(4'hA);
    chk("calendar off", 0, d[0]);
    wr(4'h1, 32'h4);
    c_dst <= 1'b1;
    c_v <= 1'b1;
    @(posedge clk);
    c_v <= 1'b0;
    rd(4'hA);
    chk("cloud summer flag", 1, d[0]);
    wr(4'h1, 32'h2);
    rd(4'hA);
    chk("winter month", 0, d[0]);
    @(posedge clk);
    c_date.mon <= 4'h6;
    rd(4'hA);
    chk("summer month", 1, d[0]);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk("reset again", 32'h0, {test_req, irq, ntp_req, evt});
    rd(4'h7);
    chk("time after reset", 13'h0000, d[20:8]);
    give_verdict();
  end
endmodule
`default_nettype wire
